// [addr_front_pkg.sv]
// Package of constants and types for the address front end.
// Assumes a single 50 MHz bus clock domain.
package addr_front_pkg;
	localparam int          ADDR_MSB       = 31;
	localparam int          ADDR_LSB       = 2;
	localparam int          SNOOP_LSB      = 4;
	localparam int          MASK_BIT       = 20;
	localparam int          PHYS_W         = ADDR_MSB - ADDR_LSB + 1;
	localparam int          SNOOP_W        = ADDR_MSB - SNOOP_LSB + 1;
	localparam logic [29:0] PHYS_RESET     = 30'h0000_0000;
	localparam logic        MASK_N_RESET   = 1'b1;
	localparam logic        STROBE_N_RESET = 1'b1;
	typedef logic [PHYS_W-1:0]  phys_addr_t;
	typedef logic [SNOOP_W-1:0] snoop_addr_t;
	typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_DATA} bus_state_t;
endpackage

// [addr_sync_if.sv]
// Interface carrying the synchronised hold and mask levels between modules.
// Assumes both modules share the bus clock.
`timescale 1ns/1ps
interface addr_sync_if;
	logic mask_n;
	logic addr_hold_req;
	logic bhold;
	logic snoop_stb_n;
	modport src (output mask_n, output addr_hold_req, output bhold, output snoop_stb_n);
	modport dst (input mask_n, input addr_hold_req, input bhold, input snoop_stb_n);
endinterface

// [addr_in_sync.sv]
// Two-stage synchronisers for the asynchronous pin inputs.
// Assumes pins arrive from outside the bus clock domain.
`timescale 1ns/1ps
module addr_in_sync
	import addr_front_pkg::*;
(
	input  wire logic  sys_clk_in,
	input  wire logic  reset_in,
	input  wire logic  addr_bit20_mask_n_in,
	input  wire logic  addr_hold_req_in,
	input  wire logic  bus_hold_in,
	input  wire logic  ext_snoop_strobe_n_in,
	addr_sync_if.src   sync
);
	localparam int           N       = 4;
	localparam logic [N-1:0] RST_VAL = {1'b1, 1'b0, 1'b0, MASK_N_RESET};
	logic [N-1:0] pins;
	logic [N-1:0] s1_r;
	logic [N-1:0] s2_r;
	logic [N-1:0] s1_nxt;
	assign pins    = {ext_snoop_strobe_n_in, bus_hold_in, addr_hold_req_in, addr_bit20_mask_n_in};
	always_comb begin
		s1_nxt = pins;
	end
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s1_r;
		end
	end
	assign sync.mask_n      = s2_r[0];
	assign sync.addr_hold_req       = s2_r[1];
	assign sync.bhold       = s2_r[2];
	assign sync.snoop_stb_n = s2_r[3];
	AST_SYNC_TWO_STAGE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		s2_r == $past(pins, 2) || $past(reset_in, 2) || $past(reset_in))
		else $error("synchroniser output is not the pin value two clocks earlier");
endmodule

// [addr_front.sv]
// Address front end: address bus, address strobe, mask of bit 20, snoop capture.
// Assumes a core request port on the bus clock and pin inputs from outside it.
// What this block does
// - While the bit 20 mask input is low, bit 20 is forced to zero for lookups and memory bus cycles; I/O cycles pass unmasked.
// - The address bus carries the memory or I/O address of every cycle started.
// - During snoops in bus hold or address hold the upper address lines are taken in and used to invalidate a cache line.
// - The address bus floats in bus hold or address hold; the strobe floats in bus hold only.
// - The strobe goes low only with a valid cycle definition and address.
// - The strobe asserts in the same clock as the new address is first driven.
// - The strobe is active low and floats in bus hold.
// - After address hold is seen the address bus stops driving in the next clock.
`timescale 1ns/1ps
module addr_front
	import addr_front_pkg::*;
(
	input  wire logic                     sys_clk_in,
	input  wire logic                     reset_in,
	input  wire logic                     addr_bit20_mask_n_in,
	input  wire logic                     addr_hold_req_in,
	input  wire logic                     bus_hold_in,
	input  wire logic                     ext_snoop_strobe_n_in,
	input  wire logic                     cyc_req_in,
	input  wire logic                     cyc_mem_in,
	input  wire addr_front_pkg::phys_addr_t cyc_addr_in,
	input  wire logic                     cyc_done_in,
	input  wire addr_front_pkg::phys_addr_t lookup_addr_in,
	input  wire addr_front_pkg::snoop_addr_t phys_addr_bus_hi_in,
	output logic                          cyc_taken_out,
	output addr_front_pkg::phys_addr_t    lookup_addr_out,
	output addr_front_pkg::phys_addr_t    phys_addr_bus_out,
	output logic                          phys_addr_bus_oe_out,
	output logic                          addr_strobe_n_out,
	output logic                          addr_strobe_n_oe_out,
	output logic                          inval_valid_out,
	output addr_front_pkg::snoop_addr_t   inval_addr_out
);
	import addr_front_pkg::*;

	addr_sync_if sync ();

	addr_in_sync u_sync (
		.sys_clk_in            (sys_clk_in),
		.reset_in              (reset_in),
		.addr_bit20_mask_n_in  (addr_bit20_mask_n_in),
		.addr_hold_req_in      (addr_hold_req_in),
		.bus_hold_in           (bus_hold_in),
		.ext_snoop_strobe_n_in (ext_snoop_strobe_n_in),
		.sync                  (sync)
	);

	// Clears bit 20 of a word address when the mask is active.
	function automatic phys_addr_t apply_mask(input phys_addr_t a, input logic mask_n);
		phys_addr_t r;
		r = a;
		if (!mask_n) begin
			r[MASK_BIT-ADDR_LSB] = 1'b0;
		end
		return r;
	endfunction

	// Snoop data sampled from the pins, two-stage like every other pin input.
	snoop_addr_t snp1_r;
	snoop_addr_t snp2_r;
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			snp1_r <= '0;
			snp2_r <= '0;
		end else begin
			snp1_r <= phys_addr_bus_hi_in;
			snp2_r <= snp1_r;
		end
	end

	bus_state_t  state_r, state_nxt;
	phys_addr_t  addr_r, addr_nxt;
	logic        oe_r, oe_nxt;
	logic        stb_r, stb_nxt;
	logic        stb_oe_r, stb_oe_nxt;
	logic        taken_r, taken_nxt;
	phys_addr_t  look_r, look_nxt;
	logic        inv_r, inv_nxt;
	snoop_addr_t inv_a_r, inv_a_nxt;
	logic        snp_prev_r, snp_prev_nxt;
	logic        hold_any;

	assign hold_any = sync.addr_hold_req | sync.bhold;

	always_comb begin
		state_nxt    = state_r;
		addr_nxt     = addr_r;
		stb_nxt      = STROBE_N_RESET;
		taken_nxt    = 1'b0;
		oe_nxt       = !hold_any;
		stb_oe_nxt   = !sync.bhold;
		look_nxt     = apply_mask(lookup_addr_in, sync.mask_n);
		unique case (state_r)
			BUS_IDLE: begin
				if (cyc_req_in && !hold_any) begin
					addr_nxt  = cyc_mem_in ? apply_mask(cyc_addr_in, sync.mask_n) : cyc_addr_in;
					stb_nxt   = 1'b0;
					taken_nxt = 1'b1;
					state_nxt = BUS_ADDR;
				end
			end
			BUS_ADDR: begin
				state_nxt = cyc_done_in ? BUS_IDLE : BUS_DATA;
			end
			BUS_DATA: begin
				if (cyc_done_in) begin
					state_nxt = BUS_IDLE;
				end
			end
			// The unused fourth code falls back to idle.
			default: begin
				state_nxt = BUS_IDLE;
			end
		endcase
		snp_prev_nxt = sync.snoop_stb_n;
		inv_nxt      = 1'b0;
		inv_a_nxt    = inv_a_r;
		if (hold_any && !sync.snoop_stb_n && snp_prev_r) begin
			inv_nxt   = 1'b1;
			inv_a_nxt = snp2_r;
		end
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_r    <= BUS_IDLE;
			addr_r     <= PHYS_RESET;
			oe_r       <= 1'b0;
			stb_r      <= STROBE_N_RESET;
			stb_oe_r   <= 1'b0;
			taken_r    <= 1'b0;
			look_r     <= PHYS_RESET;
			inv_r      <= 1'b0;
			inv_a_r    <= '0;
			snp_prev_r <= 1'b1;
		end else begin
			state_r    <= state_nxt;
			addr_r     <= addr_nxt;
			oe_r       <= oe_nxt;
			stb_r      <= stb_nxt;
			stb_oe_r   <= stb_oe_nxt;
			taken_r    <= taken_nxt;
			look_r     <= look_nxt;
			inv_r      <= inv_nxt;
			inv_a_r    <= inv_a_nxt;
			snp_prev_r <= snp_prev_nxt;
		end
	end

	assign phys_addr_bus_out    = addr_r;
	assign phys_addr_bus_oe_out = oe_r;
	assign addr_strobe_n_out    = stb_r;
	assign addr_strobe_n_oe_out = stb_oe_r;
	assign cyc_taken_out        = taken_r;
	assign lookup_addr_out      = look_r;
	assign inval_valid_out      = inv_r;
	assign inval_addr_out       = inv_a_r;

	sequence s_hold_seen;
		sync.addr_hold_req || sync.bhold;
	endsequence

	AST_FLOAT_IN_HOLD: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		s_hold_seen |=> !phys_addr_bus_oe_out)
		else $error("address bus driven during hold");
	AST_ADDR_HOLD_REQ_NEXT: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		$rose(sync.addr_hold_req) |=> !phys_addr_bus_oe_out)
		else $error("address bus not released the clock after address hold");
	AST_STROBE_FLOAT: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		sync.bhold |=> !addr_strobe_n_oe_out)
		else $error("strobe driven during bus hold");
	AST_STROBE_WITH_ADDR: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		!addr_strobe_n_out |-> phys_addr_bus_oe_out && $changed(cyc_taken_out))
		else $error("strobe not in the clock of the new address");
	AST_STROBE_CAUSE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		!addr_strobe_n_out |-> $past(cyc_req_in) && $past(state_r == BUS_IDLE))
		else $error("strobe without a started cycle");
	AST_ADDR_VALUE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		!addr_strobe_n_out && $past(sync.mask_n) |-> phys_addr_bus_out == $past(cyc_addr_in))
		else $error("address bus does not hold the requested address");
	AST_MASK_BIT20: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		!addr_strobe_n_out && $past(cyc_mem_in) && !$past(sync.mask_n)
		|-> !phys_addr_bus_out[MASK_BIT-ADDR_LSB])
		else $error("bit 20 not masked on a memory cycle");
	AST_LOOKUP_MASK: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		!$past(sync.mask_n) |-> !lookup_addr_out[MASK_BIT-ADDR_LSB])
		else $error("bit 20 not masked on cache lookup");
	AST_SNOOP_CAPTURE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		inval_valid_out |-> inval_addr_out == $past(snp2_r) && $past(hold_any))
		else $error("snoop invalidate address not captured");

	sequence s_cycle_start;
		!addr_strobe_n_out;
	endsequence

	AST_STROBE_ONE_CLOCK: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		s_cycle_start |=> addr_strobe_n_out)
		else $error("strobe held low for more than one clock");
	AST_TAKEN_WITH_STROBE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		cyc_taken_out == !addr_strobe_n_out)
		else $error("accept pulse and strobe disagree");
	AST_NO_STROBE_IN_HOLD: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		s_hold_seen |=> addr_strobe_n_out)
		else $error("strobe issued while the address bus is released");
	AST_IO_UNMASKED: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		!addr_strobe_n_out && !$past(cyc_mem_in)
		|-> phys_addr_bus_out == $past(cyc_addr_in))
		else $error("I/O cycle address altered");
	AST_ADDR_STEADY: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		addr_strobe_n_out |-> $stable(phys_addr_bus_out))
		else $error("address bus changed without a new cycle");
	AST_LOOKUP_PASS: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		$past(sync.mask_n) && !$past(reset_in)
		|-> lookup_addr_out == $past(lookup_addr_in))
		else $error("lookup address altered while the mask is inactive");
	AST_SNOOP_NEEDS_HOLD: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		!$past(hold_any) |-> !inval_valid_out)
		else $error("invalidate raised outside a hold");
endmodule

// [chipset_model.sv]
// Chipset model: drives address hold, the snoop strobe and the upper address lines.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module chipset_model
	import addr_front_pkg::*;
(
	input  wire logic                        sys_clk_in,
	input  wire addr_front_pkg::phys_addr_t  bus_in,
	input  wire logic                        bus_oe_in,
	output logic                             addr_hold_req_out,
	output logic                             snoop_n_out,
	output addr_front_pkg::snoop_addr_t      hi_out
);
	logic        drv;
	snoop_addr_t val;
	snoop_addr_t last;
	initial begin
		addr_hold_req_out = 1'b0;
		snoop_n_out = 1'b1;
		drv = 1'b0;
		val = '0;
		last = '0;
	end
	// A line nobody drives shows the inverse of its last level, never a stale value.
	assign hi_out = bus_oe_in ? bus_in[29:2] : (drv ? val : ~last);
	always @(posedge sys_clk_in) begin
		last <= hi_out;
	end
	task hold(input logic v);
		addr_hold_req_out = v;
		if (!v) begin
			drv = 1'b0;
		end
	endtask
	task snoop(input snoop_addr_t a);
		drv = 1'b1;
		val = a;
		@(posedge sys_clk_in);
		#1 snoop_n_out = 1'b0;
		@(posedge sys_clk_in);
		#1 snoop_n_out = 1'b1;
	endtask
endmodule

// [cpu_address_bus_and_a20_mask_tb_top.sv]
// Self-checking bench for the address front end.
// Assumes the chipset model stands on the pin side and the bench plays the core.
`timescale 1ns/1ps
module cpu_address_bus_and_a20_mask_tb_top;
	import addr_front_pkg::*;
	logic        sys_clk_in, reset_in, mask_n, bhold, req, mem, done, taken;
	logic        oe, strobe_n, strobe_oe, inval, addr_hold_req, snoop_n;
	phys_addr_t  addr, lk_in, lk_out, bus;
	snoop_addr_t hi, inval_a;
	int          num_errors, n_tests;
	localparam phys_addr_t A = 30'h0004_0001;
	localparam phys_addr_t B20 = 30'h0004_0000;
	addr_front dut_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.addr_bit20_mask_n_in(mask_n), .addr_hold_req_in(addr_hold_req), .bus_hold_in(bhold),
		.ext_snoop_strobe_n_in(snoop_n), .cyc_req_in(req), .cyc_mem_in(mem),
		.cyc_addr_in(addr), .cyc_done_in(done), .lookup_addr_in(lk_in),
		.phys_addr_bus_hi_in(hi), .cyc_taken_out(taken), .lookup_addr_out(lk_out),
		.phys_addr_bus_out(bus), .phys_addr_bus_oe_out(oe), .addr_strobe_n_out(strobe_n),
		.addr_strobe_n_oe_out(strobe_oe), .inval_valid_out(inval), .inval_addr_out(inval_a));
	chipset_model partner_u (.sys_clk_in(sys_clk_in), .bus_in(bus), .bus_oe_in(oe),
		.addr_hold_req_out(addr_hold_req), .snoop_n_out(snoop_n), .hi_out(hi));
	initial begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end
	task results;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk_a(input phys_addr_t g, input phys_addr_t e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t address mismatch", $time);
		end
	endtask
	task chk_b(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t flag mismatch", $time);
		end
	endtask
	task edges(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task issue(input logic m, input phys_addr_t a, input phys_addr_t e);
		req = 1'b1;
		mem = m;
		addr = a;
		for (int i = 0; i < 4 && taken !== 1'b1; i++) edges(1);
		req = 1'b0;
		if (taken !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED %0t cycle request never taken", $time);
			results();
		end
		chk_b(strobe_n, 1'b0);
		chk_b(strobe_oe, 1'b1);
		chk_b(oe, 1'b1);
		chk_a(bus, e);
		done = 1'b1;
		edges(1);
		done = 1'b0;
		chk_b(strobe_n, 1'b1);
		edges(1);
	endtask
	task t_mask;
		lk_in = A;
		issue(1'b1, A, A);
		edges(1);
		chk_a(lk_out, A);
		mask_n = 1'b0;
		edges(4);
		chk_a(lk_out, A & ~B20);
		issue(1'b1, A, A & ~B20);
		issue(1'b0, A, A);
		mask_n = 1'b1;
		edges(4);
		chk_a(lk_out, A);
	endtask
	task t_hold;
		partner_u.hold(1'b1);
		edges(2);
		chk_b(oe, 1'b1);
		edges(1);
		chk_b(oe, 1'b0);
		chk_b(strobe_oe, 1'b1);
		req = 1'b1;
		for (int i = 0; i < 3; i++) begin
			edges(1);
			chk_b(taken, 1'b0);
			chk_b(strobe_n, 1'b1);
		end
		req = 1'b0;
		partner_u.hold(1'b0);
		bhold = 1'b1;
		edges(3);
		chk_b(oe, 1'b0);
		chk_b(strobe_oe, 1'b0);
		bhold = 1'b0;
		edges(3);
		issue(1'b1, ~A, ~A);
	endtask
	task t_snoop(input logic h, input snoop_addr_t a);
		int i;
		partner_u.hold(h);
		edges(3);
		partner_u.snoop(a);
		for (i = 0; i < 5 && inval !== 1'b1; i++) edges(1);
		chk_b(inval, h);
		if (h) begin
			chk_a({2'b00, inval_a}, {2'b00, a});
		end
		if (h && inval !== 1'b1) begin
			results();
		end
		partner_u.hold(1'b0);
		edges(4);
	endtask
	initial begin
		num_errors = 0;
		n_tests = 0;
		reset_in = 1'b1;
		mask_n = 1'b1;
		bhold = 1'b0;
		req = 1'b0;
		mem = 1'b1;
		done = 1'b0;
		addr = '0;
		lk_in = '0;
		edges(5);
		reset_in = 1'b0;
		edges(3);
		t_mask();
		t_hold();
		t_snoop(1'b0, 28'h0123_4567);
		t_snoop(1'b1, 28'h0A5C_3E91);
		t_snoop(1'b1, 28'h05A3_C16E);
		results();
	end
endmodule
